//--- rtl/sbtec_params.svh
`ifndef SBTEC_PARAMS_SVH
`define SBTEC_PARAMS_SVH

// Register offsets on the plain register port.
`define SBTEC_ADDR_LOW    2'h0
`define SBTEC_ADDR_HIGH   2'h1
`define SBTEC_ADDR_CTRL   2'h2
`define SBTEC_ADDR_INT    2'h3

// Field positions in the counter control register.
`define SBTEC_MODE_HI     7
`define SBTEC_MODE_LO     6
`define SBTEC_RUN_BIT     4
`define SBTEC_EDGE_BIT    3

// Field positions in the interrupt control register.
`define SBTEC_IEN_BIT     0
`define SBTEC_IREQ_BIT    1

// Mode field encodings.
`define SBTEC_MODE_F_IDLE  2'h0
`define SBTEC_MODE_F_EVENT 2'h1
`define SBTEC_MODE_F_TIMER 2'h2
`define SBTEC_MODE_F_PULSE 2'h3

// Counter limits and reset values.
`define SBTEC_COUNT_MAX   16'hffff
`define SBTEC_COUNT_ONE   16'h0001
`define SBTEC_COUNT_RST   16'h0000
`define SBTEC_BYTE_RST    8'h00
`define SBTEC_MODE_RST    2'h0

// Instruction clock is the system clock divided by four.
`define SBTEC_DIV_RST     2'h0
`define SBTEC_DIV_ONE     2'h1
`define SBTEC_DIV_LAST    2'h3

`endif

//--- rtl/sbtec_pkg.sv
package sbtec_pkg;

  typedef logic [7:0]  sbtec_byte_t;
  typedef logic [15:0] sbtec_word_t;
  typedef logic [1:0]  sbtec_addr_t;

  typedef enum logic [1:0] {
    SBTEC_MODE_IDLE,
    SBTEC_MODE_EVENT,
    SBTEC_MODE_TIMER,
    SBTEC_MODE_PULSE
  } sbtec_mode_t;

  typedef enum logic [1:0] {
    SBTEC_PW_IDLE,
    SBTEC_PW_ARMED,
    SBTEC_PW_COUNT
  } sbtec_pw_state_t;

endpackage : sbtec_pkg

//--- rtl/sbtec_pin_if.sv
`timescale 1ns/1ps

interface sbtec_pin_if;
  logic level;
  logic rise;
  logic fall;

  modport sync (output level, output rise, output fall);
  modport core (input level, input rise, input fall);
endinterface : sbtec_pin_if

//--- rtl/sbtec_pin_sync.sv
`timescale 1ns/1ps

module sbtec_pin_sync
(
  input  wire logic  core_clk_i,
  input  wire logic  srst_i,
  input  wire logic  timer_pin_i,
  sbtec_pin_if.sync  pin
);
  import sbtec_pkg::*;

  logic meta;
  logic stable;
  logic last;

  // The first stage feeds only the second; edges look at later stages.
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      meta   <= 1'b0;
      stable <= 1'b0;
      last   <= 1'b0;
    end
    else
    begin
      meta   <= timer_pin_i;
      stable <= meta;
      last   <= stable;
    end
  end

  assign pin.level = stable;
  assign pin.rise  = stable & ~last;
  assign pin.fall  = ~stable & last;

endmodule : sbtec_pin_sync

//--- rtl/sbtec_timer.sv
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "sbtec_params.svh"

// What this block does
// - Counter steps up by one per selected tick or edge, up to all ones.
// - On overflow raise interrupt, reload from preload, keep counting.
// - With counter stopped, a preload write also loads the counter.
// - While running, a new preload waits for the next overflow reload.
// - Low byte writes go into a low byte buffer only.
// - High byte write loads high half and moves buffered low byte in.
// - High byte read latches the counter low half into the buffer.
// - Low byte read returns the latched low half, not the live one.
// - Control bits seven and six select the operating mode.
// - Run bit one lets the counter run, zero stops it.
// - Edge select bit picks the active pin transition.
// - Mode one-zero is timer mode, counting system clock divided by four.
// - Event mode counts pin edges with no prescaler.
// - Event mode counts rising edges if edge select is zero, else falling.
// - Event counting goes on in power-down; overflow is a wake-up source.
// - Mode one-one measures pulses; counting starts after an active edge.
// - Edge select zero: count from falling edge until high, then stop.
// - Edge select one: count from rising edge until low, then stop.
// - Only pulse mode clears the run bit by hardware.
// - After pulse stop, ignore the pin and hold the count until rerun.
// - Cleared interrupt enable keeps the overflow from interrupting.
// - Counting is inhibited during counter reads and preload writes.
// - Overflow sets the request flag and wakes regardless of enable.

module sbtec_timer
(
  input  wire logic                   core_clk_i,
  input  wire logic                   srst_i,
  input  wire sbtec_pkg::sbtec_addr_t addr_i,
  input  wire sbtec_pkg::sbtec_byte_t wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output sbtec_pkg::sbtec_byte_t      rdata_o,
  input  wire logic                   timer_pin_i,
  output logic                        timer_irq_o,
  output logic                        wakeup_o
);
  import sbtec_pkg::*;

  sbtec_pin_if pin ();

  sbtec_word_t     count;
  sbtec_word_t     preload;
  sbtec_byte_t     low_buf;
  logic [1:0]      mode_field;
  logic            run_bit;
  logic            edge_select_bit;
  logic            int_en;
  logic            int_req;
  logic [1:0]      div_cnt;
  logic            instr_tick;
  sbtec_mode_t     mode;
  sbtec_pw_state_t pw_state;
  sbtec_pw_state_t next_pw_state;
  logic            wr_low;
  logic            wr_high;
  logic            wr_ctrl;
  logic            wr_int;
  logic            rd_low;
  logic            rd_high;
  logic            inhibit;
  logic            event_edge;
  logic            pw_start;
  logic            pw_end;
  logic            pw_stop;
  logic            count_en;
  logic            overflow;
  sbtec_word_t     next_count;

  sbtec_pin_sync u_pin_sync
  (
    .core_clk_i  (core_clk_i),
    .srst_i      (srst_i),
    .timer_pin_i (timer_pin_i),
    .pin         (pin)
  );

  assign wr_low  = wr_i && (addr_i == `SBTEC_ADDR_LOW);
  assign wr_high = wr_i && (addr_i == `SBTEC_ADDR_HIGH);
  assign wr_ctrl = wr_i && (addr_i == `SBTEC_ADDR_CTRL);
  assign wr_int  = wr_i && (addr_i == `SBTEC_ADDR_INT);
  assign rd_low  = rd_i && (addr_i == `SBTEC_ADDR_LOW);
  assign rd_high = rd_i && (addr_i == `SBTEC_ADDR_HIGH);

  // Dropping a tick on access keeps the byte pair coherent at the cost
  // of a possible one-count error.
  assign inhibit = wr_low | wr_high | rd_low | rd_high;

  always_comb
  begin
    case (mode_field)
      `SBTEC_MODE_F_EVENT: mode = SBTEC_MODE_EVENT;
      `SBTEC_MODE_F_TIMER: mode = SBTEC_MODE_TIMER;
      `SBTEC_MODE_F_PULSE: mode = SBTEC_MODE_PULSE;
      default:             mode = SBTEC_MODE_IDLE;
    endcase
  end

  // Instruction clock enable, one pulse every four system clocks.
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      div_cnt <= `SBTEC_DIV_RST;
    else
      div_cnt <= div_cnt + `SBTEC_DIV_ONE;
  end

  assign instr_tick = (div_cnt == `SBTEC_DIV_LAST);

  // Edge choice for event mode and for the pulse boundaries.
  assign event_edge = edge_select_bit ? pin.fall : pin.rise;
  assign pw_start   = edge_select_bit ? pin.rise : pin.fall;
  assign pw_end     = edge_select_bit ? pin.fall : pin.rise;
  assign pw_stop    = (pw_state == SBTEC_PW_COUNT) && pw_end && run_bit
                      && (mode == SBTEC_MODE_PULSE);

  always_comb
  begin
    next_pw_state = pw_state;
    case (pw_state)
      SBTEC_PW_IDLE:
        if (run_bit && (mode == SBTEC_MODE_PULSE))
          next_pw_state = SBTEC_PW_ARMED;
      SBTEC_PW_ARMED:
        if (pw_start)
          next_pw_state = SBTEC_PW_COUNT;
      SBTEC_PW_COUNT:
        if (pw_end)
          next_pw_state = SBTEC_PW_IDLE;
      default:
        next_pw_state = SBTEC_PW_IDLE;
    endcase
    if (!run_bit || (mode != SBTEC_MODE_PULSE))
      next_pw_state = SBTEC_PW_IDLE;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      pw_state <= SBTEC_PW_IDLE;
    else
      pw_state <= next_pw_state;
  end

  always_comb
  begin
    count_en = 1'b0;
    case (mode)
      SBTEC_MODE_TIMER: count_en = instr_tick;
      SBTEC_MODE_EVENT: count_en = event_edge;
      SBTEC_MODE_PULSE: count_en = instr_tick && (pw_state == SBTEC_PW_COUNT);
      default:          count_en = 1'b0;
    endcase
    count_en = count_en && run_bit && !inhibit;
  end

  assign overflow = count_en && (count == `SBTEC_COUNT_MAX);

  always_comb
  begin
    next_count = count;
    if (wr_high && !run_bit)
      next_count = {wdata_i, low_buf};
    else if (overflow)
      next_count = preload;
    else if (count_en)
      next_count = count + `SBTEC_COUNT_ONE;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      count <= `SBTEC_COUNT_RST;
    else
      count <= next_count;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      preload <= `SBTEC_COUNT_RST;
    else if (wr_high)
      preload <= {wdata_i, low_buf};
  end

  // One buffer serves both write staging and read latching.
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      low_buf <= `SBTEC_BYTE_RST;
    else if (wr_low)
      low_buf <= wdata_i;
    else if (rd_high)
      low_buf <= count[7:0];
  end

  // A software write wins over the hardware stop in the same cycle.
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      mode_field      <= `SBTEC_MODE_RST;
      run_bit         <= 1'b0;
      edge_select_bit <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      mode_field      <= wdata_i[`SBTEC_MODE_HI:`SBTEC_MODE_LO];
      run_bit         <= wdata_i[`SBTEC_RUN_BIT];
      edge_select_bit <= wdata_i[`SBTEC_EDGE_BIT];
    end
    else if (pw_stop)
      run_bit <= 1'b0;
  end

  // Overflow beats a software clear so no event is lost.
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      int_en  <= 1'b0;
      int_req <= 1'b0;
    end
    else
    begin
      if (wr_int)
        int_en <= wdata_i[`SBTEC_IEN_BIT];
      if (overflow)
        int_req <= 1'b1;
      else if (wr_int)
        int_req <= wdata_i[`SBTEC_IREQ_BIT];
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      timer_irq_o <= 1'b0;
      wakeup_o    <= 1'b0;
    end
    else
    begin
      timer_irq_o <= int_req && int_en;
      wakeup_o    <= overflow;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      rdata_o <= `SBTEC_BYTE_RST;
    else if (rd_i)
    begin
      case (addr_i)
        `SBTEC_ADDR_LOW:  rdata_o <= low_buf;
        `SBTEC_ADDR_HIGH: rdata_o <= count[15:8];
        `SBTEC_ADDR_CTRL:
        begin
          rdata_o                                   <= `SBTEC_BYTE_RST;
          rdata_o[`SBTEC_MODE_HI:`SBTEC_MODE_LO]    <= mode_field;
          rdata_o[`SBTEC_RUN_BIT]                   <= run_bit;
          rdata_o[`SBTEC_EDGE_BIT]                  <= edge_select_bit;
        end
        default:
        begin
          rdata_o                  <= `SBTEC_BYTE_RST;
          rdata_o[`SBTEC_IEN_BIT]  <= int_en;
          rdata_o[`SBTEC_IREQ_BIT] <= int_req;
        end
      endcase
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  AST_INCREMENT: assert property (
    count_en && (count != `SBTEC_COUNT_MAX) && !wr_high
    |=> count == $past(count) + `SBTEC_COUNT_ONE)
    else $error("Counter did not step by one.");

  AST_OVF_RELOAD: assert property (
    overflow |=> (count == $past(preload)) && int_req)
    else $error("Overflow did not reload and flag.");

  AST_STOPPED_LOAD: assert property (
    wr_high && !run_bit |=> count == {$past(wdata_i), $past(low_buf)})
    else $error("Stopped counter missed the preload.");

  AST_RUNNING_HOLD: assert property (
    wr_high && run_bit |=> count == $past(count))
    else $error("Running counter took the preload early.");

  AST_LOW_BUFFERED: assert property (
    wr_low |=> (count == $past(count)) && (preload == $past(preload))
               && (low_buf == $past(wdata_i)))
    else $error("Low byte write reached the counter.");

  AST_HIGH_LATCH: assert property (
    rd_high |=> low_buf == $past(count[7:0]))
    else $error("High read did not latch the low half.");

  AST_LOW_READ: assert property (
    rd_low |=> rdata_o == $past(low_buf))
    else $error("Low read did not return the latched byte.");

  AST_STOPPED_IDLE: assert property (
    !run_bit && !wr_high |=> count == $past(count))
    else $error("Counter moved while stopped.");

  AST_TIMER_RATE: assert property (
    count_en && (mode == SBTEC_MODE_TIMER) |=> !count_en [*3])
    else $error("Timer counted faster than one per four clocks.");

  AST_EVENT_EDGE: assert property (
    (mode == SBTEC_MODE_EVENT) && run_bit && !inhibit
    && (edge_select_bit ? $fell(pin.level) : $rose(pin.level))
    |-> count_en)
    else $error("Event edge was not counted.");

  AST_PULSE_STOP: assert property (
    pw_stop && !wr_ctrl |=> !run_bit ##1 (pw_state == SBTEC_PW_IDLE))
    else $error("Pulse end did not stop the counter.");

  AST_RUN_SOFT_ONLY: assert property (
    (mode != SBTEC_MODE_PULSE) && !wr_ctrl |=> run_bit == $past(run_bit))
    else $error("Run bit changed without software.");

  AST_IRQ_MASK: assert property (
    timer_irq_o |-> $past(int_en) && $past(int_req))
    else $error("Interrupt raised while disabled.");

  AST_WAKE: assert property (
    overflow |=> wakeup_o && int_req)
    else $error("Overflow gave no wake-up.");

  COV_OVERFLOW: cover property (overflow);
  COV_PULSE_DONE: cover property (
    (pw_state == SBTEC_PW_ARMED) ##[1:200] pw_stop);
  COV_EVENT_COUNT: cover property (
    (mode == SBTEC_MODE_EVENT) && count_en);
  COV_READ_PAIR: cover property (rd_high ##1 rd_low);

endmodule : sbtec_timer

//--- test/sbtec_pin_src.sv
`timescale 1ns/1ps

module sbtec_pin_src
(
  input  wire logic clk_i,
  output logic      pin_o
);
  initial pin_o = 1'b0;

  // Levels move just after an edge and stand for whole cycles.
  // The core resynchronises them, so widths are only known to a tick.
  task automatic hold(input logic v, input int n);
    @(posedge clk_i);
    pin_o <= v;
    repeat (n) @(posedge clk_i);
  endtask : hold

  task automatic pulse(input logic v, input int n);
    hold(v, n);
    hold(~v, n);
  endtask : pulse
endmodule : sbtec_pin_src

//--- test/sixteen_bit_timer_event_counter_test.sv
`timescale 1ns/1ps

module sixteen_bit_timer_event_counter_test;
  import sbtec_pkg::*;
  logic        core_clk_i;
  logic        srst_i;
  sbtec_addr_t addr_i;
  sbtec_byte_t wdata_i;
  logic        wr_i;
  logic        rd_i;
  sbtec_byte_t rdata_o;
  logic        timer_pin_i;
  logic        timer_irq_o;
  logic        wakeup_o;
  int          errors;
  int          compares;
  int          wakes;
  int          n;
  sbtec_byte_t b;
  sbtec_word_t w0;
  sbtec_word_t w1;

  sbtec_timer dut
  (
    .core_clk_i  (core_clk_i),
    .srst_i      (srst_i),
    .addr_i      (addr_i),
    .wdata_i     (wdata_i),
    .wr_i        (wr_i),
    .rd_i        (rd_i),
    .rdata_o     (rdata_o),
    .timer_pin_i (timer_pin_i),
    .timer_irq_o (timer_irq_o),
    .wakeup_o    (wakeup_o)
  );

  sbtec_pin_src src
  (
    .clk_i (core_clk_i),
    .pin_o (timer_pin_i)
  );

  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i)
    if (wakeup_o === 1'b1)
      wakes++;

  // Addresses: 0 low byte, 1 high byte, 2 control, 3 interrupt control.
  task automatic wr(input sbtec_addr_t a, input sbtec_byte_t d);
    @(posedge core_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input sbtec_addr_t a, output sbtec_byte_t d);
    @(posedge core_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd

  task automatic wr16(input sbtec_word_t w);
    wr(2'h0, w[7:0]);
    wr(2'h1, w[15:8]);
  endtask : wr16

  task automatic rd16(output sbtec_word_t w);
    sbtec_byte_t h;
    sbtec_byte_t l;
    rd(2'h1, h);
    rd(2'h0, l);
    w = {h, l};
  endtask : rd16

  task automatic chk8(input string nm, input sbtec_byte_t e,
                      input sbtec_byte_t g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic chk1(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1

  // Tick phase and pin resynchronisation blur counts by one tick.
  task automatic chk_rng(input string nm, input logic [31:0] lo,
                         input logic [31:0] hi, input sbtec_word_t g);
    compares++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      errors++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng

  task automatic wait_wake(output int k);
    k = 0;
    do
    begin
      @(posedge core_clk_i);
      #1;
      k++;
    end while (wakeup_o !== 1'b1 && k < 200);
  endtask : wait_wake

  task automatic wrap_up();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  initial
  begin
    #100_000;
    errors++;
    wrap_up();
  end

  initial
  begin
    srst_i   = 1'b1;
    addr_i   = 2'h0;
    wdata_i  = 8'h00;
    wr_i     = 1'b0;
    rd_i     = 1'b0;
    errors   = 0;
    compares = 0;
    wakes    = 0;
    repeat (4) @(posedge core_clk_i);
    srst_i <= 1'b0;
    for (int a = 0; a < 4; a++)
    begin
      rd(sbtec_addr_t'(a), b);
      chk8("reset", 8'h00, b);
    end
    wr(2'h2, 8'h27);
    rd(2'h2, b);
    chk8("ctrl_rsvd", 8'h00, b);
    wr16(16'h1234);
    rd16(w0);
    chk_rng("load_stop", 16'h1234, 16'h1234, w0);
    wr(2'h0, 8'h56);
    rd(2'h1, b);
    chk8("low_buffered", 8'h12, b);
    rd(2'h0, b);
    chk8("low_latched", 8'h34, b);
    // The high read latched 0x34 into the shared buffer.
    wr(2'h1, 8'h78);
    rd16(w0);
    chk_rng("high_moves", 16'h7834, 16'h7834, w0);
    wr16(16'hfff0);
    wr(2'h3, 8'h01);
    wr(2'h2, 8'h90);
    wait_wake(n);
    chk_rng("ovf_wait", 60, 72, 16'(n));
    @(posedge core_clk_i);
    #1;
    chk1("irq_on", 1'b1, timer_irq_o);
    rd(2'h3, b);
    chk8("int_flag", 8'h03, b);
    wr(2'h3, 8'h01);
    repeat (2) @(posedge core_clk_i);
    #1;
    chk1("irq_off", 1'b0, timer_irq_o);
    wr16(16'h0010);
    rd16(w0);
    chk8("run_preload", 8'hff, w0[15:8]);
    wait_wake(n);
    rd16(w0);
    chk_rng("reload", 16'h0010, 16'h0014, w0);
    wr(2'h2, 8'h80);
    rd16(w0);
    repeat (20) @(posedge core_clk_i);
    rd16(w1);
    chk_rng("stopped", w0, w0, w1);
    wr16(16'h0000);
    wr(2'h2, 8'h90);
    repeat (40) @(posedge core_clk_i);
    wr(2'h2, 8'h80);
    rd16(w0);
    chk_rng("tmr_rate", 9, 11, w0);
    wr(2'h2, 8'h10);
    repeat (40) @(posedge core_clk_i);
    rd16(w1);
    chk_rng("idle", w0, w0, w1);
    wr(2'h2, 8'h40);
    wr16(16'h0000);
    wr(2'h2, 8'h50);
    repeat (3) src.pulse(1'b1, 4);
    repeat (6) @(posedge core_clk_i);
    rd16(w0);
    chk_rng("evt_rise", 3, 3, w0);
    wr(2'h2, 8'h58);
    repeat (2) src.pulse(1'b1, 4);
    repeat (6) @(posedge core_clk_i);
    rd16(w0);
    chk_rng("evt_fall", 5, 5, w0);
    rd(2'h2, b);
    chk8("evt_run", 8'h58, b);
    wr(2'h2, 8'h48);
    wr16(16'hffff);
    wr(2'h3, 8'h00);
    wr(2'h2, 8'h58);
    n = wakes;
    src.pulse(1'b1, 4);
    repeat (6) @(posedge core_clk_i);
    #1;
    chk_rng("evt_wake", n + 1, n + 1, 16'(wakes));
    chk1("irq_masked", 1'b0, timer_irq_o);
    rd(2'h3, b);
    chk8("flag_masked", 8'h02, b);
    src.hold(1'b1, 4);
    wr(2'h2, 8'hc0);
    wr16(16'h0000);
    wr(2'h2, 8'hd0);
    // Armed but idle: no counting until the falling edge.
    repeat (20) @(posedge core_clk_i);
    src.hold(1'b0, 40);
    src.hold(1'b1, 10);
    rd(2'h2, b);
    chk8("pw0_run", 8'hc0, b);
    rd16(w0);
    chk_rng("pw0_width", 9, 11, w0);
    src.pulse(1'b0, 10);
    repeat (6) @(posedge core_clk_i);
    rd16(w1);
    chk_rng("pw_hold", w0, w0, w1);
    wr(2'h2, 8'hc8);
    src.hold(1'b0, 4);
    wr16(16'h0000);
    wr(2'h2, 8'hd8);
    src.hold(1'b1, 20);
    src.hold(1'b0, 10);
    rd(2'h2, b);
    chk8("pw1_run", 8'hc8, b);
    rd16(w0);
    chk_rng("pw1_width", 4, 6, w0);
    wrap_up();
  end
endmodule : sixteen_bit_timer_event_counter_test
